/* File: hdl/pmwc_defines.vh */
// Constants for the power mode and wake controller.
// Assumes a 100 MHz aclk and 32-bit AXI4-Lite register access.
`ifndef PMWC_DEFINES_VH
`define PMWC_DEFINES_VH

// Register byte addresses
`define PMWC_ADDR_PWR_CTRL   4'h0
`define PMWC_ADDR_CLK_CTRL   4'h4
`define PMWC_ADDR_STATE      4'h8
`define PMWC_ADDR_IRQ_STAT   4'hC
`define PMWC_ADDR_IRQ_MASK   4'h0
`define PMWC_ADDR_HI_MASK    5'h10

// power_control_reg fields
`define PMWC_PC_IDLE         0
`define PMWC_PC_PDOWN        1
`define PMWC_PC_SER_WAKE     2
`define PMWC_PC_EXT0_WAKE    3
`define PMWC_PC_RESET        4'h0

// clock_control_reg fields
`define PMWC_CC_OSC_HALT     0
`define PMWC_CC_RESET        1'h0

// Status event bits
`define PMWC_EV_IDLE_WAKE    0
`define PMWC_EV_TIC_WAKE     1
`define PMWC_EV_SER_WAKE     2
`define PMWC_EV_EXT0_WAKE    3
`define PMWC_EV_PIN_RESET    4
`define PMWC_EV_POR_DONE     5
`define PMWC_EV_W            6
`define PMWC_EV_RESET        6'h00

// Power states
`define PMWC_ST_RUN          2'h0
`define PMWC_ST_IDLE         2'h1
`define PMWC_ST_PDOWN        2'h2
`define PMWC_ST_RESET        2'h3

// Wake source codes
`define PMWC_WS_NONE         2'h0
`define PMWC_WS_TIC          2'h1
`define PMWC_WS_SER          2'h2
`define PMWC_WS_EXT0         2'h3

// Power-on release time
`define PMWC_POR_TIME_MS     128
`define PMWC_CLK_KHZ         100000
// Same count as the two figures above, sized for the timer register
`define PMWC_POR_CYCLES      24'hC3_5000

// AXI responses
`define PMWC_RESP_OKAY       2'h0
`define PMWC_RESP_SLVERR     2'h2

`define PMWC_ZERO32          32'h0000_0000

`endif

/* File: hdl/pmwc_top.v */
// Power mode and wake controller: idle, power-down, wake and power-on reset.
// Assumes a single 100 MHz aclk, an AXI4-Lite master, and comparator
// levels from the supply monitor that are synchronous to aclk.
//
// Overview of operation
// - Software selects idle or full power-down from normal operation.
// - Idle stops the PLL core clock; the oscillator keeps running.
// - Peripherals keep their clock and stay functional during idle.
// - Core registers, stack pointer and program counter keep contents in idle.
// - Port and converter pins keep their entry states during idle.
// - Idle ends on any enabled interrupt or a hardware reset.
// - Power-down stops both the PLL and the core clock.
// - Oscillator stops in power-down only when the halt bit is set.
// - Interval counter may run in power-down; other peripherals shut down.
// - Power-down holds port levels; converter outputs go high impedance.
// - Reset pin ends power-down, defaults registers, boots on release.
// - Power cycle defaults registers; boot follows about 128 ms later.
// - Interval counter interrupt ends power-down; return resumes after entry.
// - Serial interrupt wakes power-down only with serial wake enable set.
// - External interrupt zero wakes power-down only with its enable set.
// - Reset held below 2.45 V, then released 128 ms after rising.
// - On falling supply, reset stays asserted down to 1 V.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "pmwc_defines.vh"

module pmwc_top #(
    parameter [23:0] POR_CYCLES = `PMWC_POR_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        instr_end,
    input  wire        enabled_irq,
    input  wire        interval_counter_irq,
    input  wire        serial_irq,
    input  wire        ext_interrupt_zero_n,
    input  wire        reset_pin,
    input  wire        vdd_above_por,
    input  wire        vdd_above_min,
    output reg         core_clk_en,
    output reg         pll_en,
    output reg         osc_en,
    output reg         periph_clk_en,
    output reg         interval_counter_clk_en,
    output reg         core_hold,
    output reg         pin_hold,
    output reg         dac_hiz,
    output reg         chip_reset_n,
    output reg         wake_pulse,
    output reg  [1:0]  wake_source,
    output reg         irq
);

    function sel_addr;
        input [4:0] addr;
        input [3:0] low;
        input       hi;
        begin
            sel_addr = (addr[3:0] == low) && (addr[4] == hi);
        end
    endfunction

    // Write-one-to-clear with set winning over clear in the same cycle
    function [`PMWC_EV_W-1:0] w1c;
        input [`PMWC_EV_W-1:0] cur;
        input [`PMWC_EV_W-1:0] clr;
        input [`PMWC_EV_W-1:0] set;
        begin
            w1c = (cur & ~clr) | set;
        end
    endfunction

    reg  [1:0]            state;
    reg  [1:0]            next_state;
    reg  [3:0]            power_control_reg;
    reg                   clock_control_reg;
    reg  [`PMWC_EV_W-1:0] irq_status;
    reg  [`PMWC_EV_W-1:0] irq_mask;
    reg  [23:0]           por_count;
    reg                   por_hold;
    reg                   reset_pin_d;
    reg  [4:0]            aw_addr;
    reg                   aw_got;
    reg  [31:0]           w_data;
    reg  [3:0]            w_strb;
    reg                   w_got;

    reg  [`PMWC_EV_W-1:0] ev_set;
    reg  [1:0]            next_wake_source;
    reg                   next_wake_pulse;

    wire sys_reset = por_hold || reset_pin;
    wire wr_fire   = aw_got && w_got && !s_axi_bvalid;
    wire pc_wr     = wr_fire && sel_addr(aw_addr, `PMWC_ADDR_PWR_CTRL, 1'b0);
    wire cc_wr     = wr_fire && sel_addr(aw_addr, `PMWC_ADDR_CLK_CTRL, 1'b0);
    wire st_wr     = wr_fire && sel_addr(aw_addr, `PMWC_ADDR_IRQ_STAT, 1'b0);
    wire mk_wr     = wr_fire && sel_addr(aw_addr, `PMWC_ADDR_IRQ_MASK, 1'b1);
    wire wr_ok     = pc_wr || cc_wr || st_wr || mk_wr
                     || sel_addr(aw_addr, `PMWC_ADDR_STATE, 1'b0);

    // Interrupt zero is level sampled; the far end keeps it high around
    // the entry instruction, so no stale low can wake us at once.
    wire ext0_wake = !ext_interrupt_zero_n
                     && power_control_reg[`PMWC_PC_EXT0_WAKE];
    wire ser_wake  = serial_irq
                     && power_control_reg[`PMWC_PC_SER_WAKE];

    // Power-on timer: restarts whenever the supply is below threshold
    always @(posedge aclk) begin
        if (!aresetn) begin
            por_count <= 24'h00_0000;
            por_hold  <= 1'b1;
        end else if (!vdd_above_por) begin
            // Covers the falling edge too: held until the monitor dies
            por_count <= 24'h00_0000;
            por_hold  <= 1'b1;
        end else if (por_count >= POR_CYCLES - 24'h00_0001) begin
            por_hold  <= 1'b0;
        end else begin
            por_count <= por_count + 24'h00_0001;
        end
    end

    always @* begin
        next_state       = state;
        next_wake_source = `PMWC_WS_NONE;
        next_wake_pulse  = 1'b0;
        case (state)
            `PMWC_ST_RESET: begin
                if (!sys_reset) begin
                    next_state = `PMWC_ST_RUN;
                end
            end
            `PMWC_ST_RUN: begin
                if (instr_end
                    && power_control_reg[`PMWC_PC_PDOWN]) begin
                    next_state = `PMWC_ST_PDOWN;
                end else if (instr_end
                             && power_control_reg[`PMWC_PC_IDLE]) begin
                    next_state = `PMWC_ST_IDLE;
                end
            end
            `PMWC_ST_IDLE: begin
                if (enabled_irq) begin
                    next_state      = `PMWC_ST_RUN;
                    next_wake_pulse = 1'b1;
                end
            end
            `PMWC_ST_PDOWN: begin
                if (interval_counter_irq) begin
                    next_state       = `PMWC_ST_RUN;
                    next_wake_pulse  = 1'b1;
                    next_wake_source = `PMWC_WS_TIC;
                end else if (ser_wake) begin
                    next_state       = `PMWC_ST_RUN;
                    next_wake_pulse  = 1'b1;
                    next_wake_source = `PMWC_WS_SER;
                end else if (ext0_wake) begin
                    next_state       = `PMWC_ST_RUN;
                    next_wake_pulse  = 1'b1;
                    next_wake_source = `PMWC_WS_EXT0;
                end
            end
            default: begin
                next_state = `PMWC_ST_RESET;
            end
        endcase
        if (sys_reset) begin
            next_state = `PMWC_ST_RESET;
        end
    end

    always @* begin
        ev_set = `PMWC_EV_RESET;
        ev_set[`PMWC_EV_IDLE_WAKE] = (state == `PMWC_ST_IDLE)
                                     && next_wake_pulse;
        ev_set[`PMWC_EV_TIC_WAKE]  = next_wake_source == `PMWC_WS_TIC;
        ev_set[`PMWC_EV_SER_WAKE]  = next_wake_source == `PMWC_WS_SER;
        ev_set[`PMWC_EV_EXT0_WAKE] = next_wake_source == `PMWC_WS_EXT0;
        ev_set[`PMWC_EV_PIN_RESET] = reset_pin && !reset_pin_d;
        ev_set[`PMWC_EV_POR_DONE]  = (state == `PMWC_ST_RESET)
                                     && !sys_reset;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state       <= `PMWC_ST_RESET;
            reset_pin_d <= 1'b0;
            wake_pulse  <= 1'b0;
            wake_source <= `PMWC_WS_NONE;
        end else begin
            state       <= next_state;
            reset_pin_d <= reset_pin;
            wake_pulse  <= next_wake_pulse;
            wake_source <= next_wake_source;
        end
    end

    // Mode bits clear on wake so the core does not fall straight back in
    always @(posedge aclk) begin
        if (!aresetn || sys_reset) begin
            power_control_reg <= `PMWC_PC_RESET;
            clock_control_reg <= `PMWC_CC_RESET;
        end else begin
            if (pc_wr && w_strb[0]) begin
                power_control_reg <= w_data[3:0];
            end else if (next_wake_pulse) begin
                power_control_reg[`PMWC_PC_IDLE]  <= 1'b0;
                power_control_reg[`PMWC_PC_PDOWN] <= 1'b0;
            end
            if (cc_wr && w_strb[0]) begin
                clock_control_reg <= w_data[`PMWC_CC_OSC_HALT];
            end
        end
    end

    // Status and mask survive chip resets so software can see the cause
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= `PMWC_EV_RESET;
            irq_mask   <= `PMWC_EV_RESET;
            irq        <= 1'b0;
        end else begin
            irq_status <= w1c(irq_status,
                              (st_wr && w_strb[0])
                              ? w_data[`PMWC_EV_W-1:0]
                              : `PMWC_EV_RESET,
                              ev_set);
            if (mk_wr && w_strb[0]) begin
                irq_mask <= w_data[`PMWC_EV_W-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // Clock gating and pin control taken from the next state; chip_reset_n from sys_reset and vdd_above_min
    always @(posedge aclk) begin
        if (!aresetn) begin
            core_clk_en             <= 1'b0;
            pll_en                  <= 1'b1;
            osc_en                  <= 1'b1;
            periph_clk_en           <= 1'b0;
            interval_counter_clk_en <= 1'b0;
            core_hold               <= 1'b0;
            pin_hold                <= 1'b0;
            dac_hiz                 <= 1'b0;
            chip_reset_n            <= 1'b0;
        end else begin
            core_clk_en   <= next_state == `PMWC_ST_RUN;
            pll_en        <= next_state != `PMWC_ST_PDOWN;
            osc_en        <= !(next_state == `PMWC_ST_PDOWN
                               && clock_control_reg);
            periph_clk_en <= next_state == `PMWC_ST_RUN
                             || next_state == `PMWC_ST_IDLE;
            // Interval counter runs off the oscillator, so it stops with it
            interval_counter_clk_en <= next_state != `PMWC_ST_RESET
                                       && !(next_state == `PMWC_ST_PDOWN
                                            && clock_control_reg);
            core_hold     <= next_state == `PMWC_ST_IDLE
                             || next_state == `PMWC_ST_PDOWN;
            pin_hold      <= next_state == `PMWC_ST_IDLE
                             || next_state == `PMWC_ST_PDOWN;
            dac_hiz       <= next_state == `PMWC_ST_PDOWN;
            // Below 1 V the monitor cannot drive; low is the safe default
            chip_reset_n  <= !(sys_reset || !vdd_above_min);
        end
    end

    // AXI4-Lite write: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PMWC_RESP_OKAY;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 5'h00;
            w_data        <= `PMWC_ZERO32;
            w_strb        <= 4'h0;
        end else begin
            s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid
                             && !s_axi_bvalid;
            s_axi_wready  <= !w_got && !s_axi_wready && s_axi_wvalid
                             && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `PMWC_RESP_OKAY
                                      : `PMWC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `PMWC_ZERO32;
            s_axi_rresp   <= `PMWC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid
                             && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `PMWC_RESP_OKAY;
                s_axi_rdata  <= `PMWC_ZERO32;
                if (sel_addr(s_axi_araddr, `PMWC_ADDR_PWR_CTRL, 1'b0)) begin
                    s_axi_rdata[3:0] <= power_control_reg;
                end else if (sel_addr(s_axi_araddr,
                                      `PMWC_ADDR_CLK_CTRL, 1'b0)) begin
                    s_axi_rdata[0] <= clock_control_reg;
                end else if (sel_addr(s_axi_araddr,
                                      `PMWC_ADDR_STATE, 1'b0)) begin
                    s_axi_rdata[1:0] <= state;
                    s_axi_rdata[2]   <= por_hold;
                end else if (sel_addr(s_axi_araddr,
                                      `PMWC_ADDR_IRQ_STAT, 1'b0)) begin
                    s_axi_rdata[`PMWC_EV_W-1:0] <= irq_status;
                end else if (sel_addr(s_axi_araddr,
                                      `PMWC_ADDR_IRQ_MASK, 1'b1)) begin
                    s_axi_rdata[`PMWC_EV_W-1:0] <= irq_mask;
                end else begin
                    s_axi_rresp <= `PMWC_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pmwc_top

/* File: sim/pmwc_core_model.sv */
// Core and wake-source stand-in: instruction-end pulses and the ext0 pin.
// Assumes the bench commands ext0 through ext0_req.
`timescale 1ns/1ps

module pmwc_core_model (
    input  wire aclk,
    input  wire aresetn,
    input  wire core_clk_en,
    input  wire chip_reset_n,
    input  wire ext0_req,
    output reg  instr_end,
    output reg  ext_interrupt_zero_n
);
    reg [1:0] phase;
    reg [1:0] gap;

    // An instruction ends every fourth cycle while the core is clocked
    always @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 2'h0;
            gap <= 2'h0;
            instr_end <= 1'b0;
            ext_interrupt_zero_n <= 1'b1;
        end else begin
            phase <= phase + 2'h1;
            instr_end <= core_clk_en && chip_reset_n && phase == 2'h3;
            gap <= instr_end ? 2'h3 : (gap != 2'h0 ? gap - 2'h1 : 2'h0);
            // Pin held high close to an instruction end
            ext_interrupt_zero_n <= !(ext0_req && gap == 2'h0 && !instr_end);
        end
    end
endmodule // pmwc_core_model

/* File: sim/pmwc_asserts.sv */
// Port-level checker for the power mode and wake controller.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ps
`include "pmwc_defines.vh"

module pmwc_asserts #(
    parameter [23:0] POR_CYCLES = 24'hC3_5000
) (
    input wire       aclk,
    input wire       aresetn,
    input wire       interval_counter_irq,
    input wire       serial_irq,
    input wire       ext_interrupt_zero_n,
    input wire       reset_pin,
    input wire       vdd_above_por,
    input wire       vdd_above_min,
    input wire       core_clk_en,
    input wire       pll_en,
    input wire       osc_en,
    input wire       periph_clk_en,
    input wire       interval_counter_clk_en,
    input wire       core_hold,
    input wire       pin_hold,
    input wire       dac_hiz,
    input wire       chip_reset_n,
    input wire       wake_pulse,
    input wire [1:0] wake_source
);
    reg [23:0] vdd_cnt;

    // Saturating count of cycles with the supply above the release level
    always @(posedge aclk) begin
        if (!aresetn || !vdd_above_por) begin
            vdd_cnt <= 24'h00_0000;
        end else if (vdd_cnt != 24'hFF_FFFF) begin
            vdd_cnt <= vdd_cnt + 24'h00_0001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_tic_wake;
        wake_pulse && wake_source == `PMWC_WS_TIC && core_clk_en
        ##1 !wake_pulse;
    endsequence

    a_idle_clocks:
    assert property (core_hold && !dac_hiz |-> !core_clk_en && osc_en
        && periph_clk_en && pin_hold) else $error("idle clocks wrong");
    a_pd_clocks:
    assert property (dac_hiz |-> !pll_en && !core_clk_en && !periph_clk_en
        && pin_hold && core_hold && interval_counter_clk_en == osc_en)
        else $error("power-down clocks wrong");
    a_osc_run:
    assert property (!dac_hiz |-> osc_en) else $error("oscillator stopped");
    a_tic_wake:
    assert property (dac_hiz && interval_counter_irq && !reset_pin
        && vdd_above_por |-> ##[1:3] s_tic_wake) else $error("no tic wake");
    a_ser_wake:
    assert property (wake_pulse && wake_source == `PMWC_WS_SER
        |-> $past(serial_irq)) else $error("serial wake without irq");
    a_ext0_wake:
    assert property (wake_pulse && wake_source == `PMWC_WS_EXT0
        |-> !$past(ext_interrupt_zero_n)) else $error("ext0 wake wrong");
    a_pd_stays:
    assert property (dac_hiz && !interval_counter_irq && !serial_irq
        && ext_interrupt_zero_n && !reset_pin && vdd_above_por
        && vdd_above_min |=> dac_hiz) else $error("power-down left early");
    a_pin_reset:
    assert property (reset_pin |-> ##[1:2] !chip_reset_n)
        else $error("reset pin ignored");
    a_por_floor:
    assert property (!vdd_above_por |-> ##[1:2] !chip_reset_n)
        else $error("low supply not in reset");
    a_min_floor:
    assert property (!vdd_above_min |-> ##[1:2] !chip_reset_n)
        else $error("collapsed supply not in reset");
    a_por_timer:
    assert property ($rose(chip_reset_n) |-> vdd_cnt >= POR_CYCLES)
        else $error("reset released early");
endmodule // pmwc_asserts

bind pmwc_top pmwc_asserts #(.POR_CYCLES(POR_CYCLES)) pmwc_asserts_i (.*);

/* File: sim/pmwc_top_tb.sv */
// Self-checking bench for the power mode and wake controller.
// Assumes a short power-on count so the release timer runs quickly.
`timescale 1ns/1ps
`include "pmwc_defines.vh"

module pmwc_top_tb;
    reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready, enabled_irq, serial_irq;
    reg         interval_counter_irq, reset_pin, ext0_req;
    reg         vdd_above_por, vdd_above_min;
    reg  [4:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata;
    wire [2:0]  s_axi_awprot = 3'h0;
    wire [2:0]  s_axi_arprot = 3'h0;
    wire [3:0]  s_axi_wstrb = 4'hF;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, instr_end, ext_interrupt_zero_n, core_clk_en;
    wire        pll_en, osc_en, periph_clk_en, interval_counter_clk_en;
    wire        core_hold, pin_hold, dac_hiz, chip_reset_n, wake_pulse, irq;
    wire [1:0]  s_axi_bresp, s_axi_rresp, wake_source;
    wire [31:0] s_axi_rdata;
    logic [33:0] rd_q[$];
    logic [1:0]  b_q[$];
    logic [1:0]  wk_q[$];
    logic [31:0] pc_t [4] = '{32'h0000_0002, 32'h0000_0006,
                              32'h0000_000A, 32'h0000_0003};
    logic [3:0]  cc_t = 4'b1010;
    logic [1:0]  src_t [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
    integer      fails, n_compared, cyc, i;

    pmwc_top #(.POR_CYCLES(24'h00_0014)) pmwc_top_i (.*);
    pmwc_core_model pmwc_core_model_i (.*);

    always #5 aclk = ~aclk;

    task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task close_out;
        $display("fails %0d n_compared %0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task wr(input [4:0] a, input [31:0] d, input [1:0] r);
        reg aw, w;
        b_q.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task rd(input [4:0] a, input [31:0] d, input [1:0] r);
        rd_q.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task pd_wake(input [31:0] pc, input cc, input [1:0] src);
        wr(5'h04, cc ? 32'h0000_0001 : 32'h0000_0000, 2'h0);
        wr(5'h00, pc, 2'h0);
        while (!dac_hiz) @(posedge aclk);
        @(posedge aclk);
        chk("pll_core", {pll_en, core_clk_en}, 2'h0);
        chk("osc_en", osc_en, !cc);
        chk("tic_per", {interval_counter_clk_en, periph_clk_en}, {!cc, 1'b0});
        chk("pin_hold", pin_hold, 1'b1);
        repeat ($urandom % 8) @(posedge aclk);
        wk_q.push_back(src);
        interval_counter_irq <= src == `PMWC_WS_TIC;
        serial_irq <= src == `PMWC_WS_SER;
        ext0_req <= src == `PMWC_WS_EXT0;
        do @(posedge aclk); while (!wake_pulse);
        interval_counter_irq <= 1'b0;
        serial_irq <= 1'b0;
        ext0_req <= 1'b0;
        chk("core_clk", core_clk_en, 1'b1);
        rd(5'h00, pc & 32'h0000_000C, 2'h0);
    endtask

    // Results are judged where they appear, against the queued notes
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (s_axi_bvalid && s_axi_bready) chk("bresp", s_axi_bresp, b_q.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
        if (wake_pulse) chk("wake_src", wake_source, wk_q.size() ? wk_q.pop_front() : 2'bxx);
        if (cyc == 5000) begin
            fails = fails + 1;
            close_out;
        end
    end

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, enabled_irq, serial_irq} = 4'h0;
        {interval_counter_irq, reset_pin, ext0_req} = 3'h0;
        {vdd_above_por, vdd_above_min} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h000_0000_0000;
        {fails, n_compared, cyc} = 96'h0;
        void'($urandom(32'h1340));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        while (!chip_reset_n) @(posedge aclk);
        rd(5'h08, 32'h0000_0000, 2'h0);
        rd(5'h0C, 32'h0000_0020, 2'h0);
        rd(5'h00, 32'h0000_0000, 2'h0);
        rd(5'h04, 32'h0000_0000, 2'h0);
        rd(5'h14, 32'h0000_0000, 2'h2);
        wr(5'h14, 32'hFFFF_FFFF, 2'h2);
        wr(5'h10, $urandom | 32'h0000_003F, 2'h0);
        rd(5'h10, 32'h0000_003F, 2'h0);
        repeat (2) @(posedge aclk);
        chk("irq_on", irq, 1'b1);
        wr(5'h0C, 32'h0000_003F, 2'h0);
        repeat (2) @(posedge aclk);
        chk("irq_clr", irq, 1'b0);
        wr(5'h00, 32'h0000_0001, 2'h0);
        while (!core_hold) @(posedge aclk);
        @(posedge aclk);
        chk("idle_out", {pll_en, osc_en, periph_clk_en, core_clk_en, dac_hiz}, 5'h1C);
        rd(5'h08, 32'h0000_0001, 2'h0);
        wk_q.push_back(`PMWC_WS_NONE);
        enabled_irq <= 1'b1;
        do @(posedge aclk); while (!wake_pulse);
        enabled_irq <= 1'b0;
        rd(5'h00, 32'h0000_0000, 2'h0);
        for (i = 0; i < 4; i = i + 1) pd_wake(pc_t[i], cc_t[i], src_t[i]);
        rd(5'h0C, 32'h0000_000F, 2'h0);
        chk("irq_ev", irq, 1'b1);
        wr(5'h10, 32'h0000_0000, 2'h0);
        repeat (2) @(posedge aclk);
        chk("irq_mask", irq, 1'b0);
        // Serial request without its enable must leave power-down alone
        wr(5'h00, 32'h0000_0002, 2'h0);
        while (!dac_hiz) @(posedge aclk);
        serial_irq <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("pd_hold", dac_hiz, 1'b1);
        reset_pin <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("pin_rst", chip_reset_n, 1'b0);
        serial_irq <= 1'b0;
        reset_pin <= 1'b0;
        while (!chip_reset_n) @(posedge aclk);
        @(posedge aclk);
        chk("pin_exit", dac_hiz, 1'b0);
        rd(5'h00, 32'h0000_0000, 2'h0);
        vdd_above_por <= 1'b0;
        vdd_above_min <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("por_low", chip_reset_n, 1'b0);
        vdd_above_min <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("por_fall", chip_reset_n, 1'b0);
        vdd_above_por <= 1'b1;
        i = 0;
        while (!chip_reset_n) begin
            @(posedge aclk);
            i = i + 1;
        end
        chk("por_wait", i > 20, 1'b1);
        rd(5'h08, 32'h0000_0000, 2'h0);
        close_out;
    end
endmodule // pmwc_top_tb
